// >>> include/uihc_regs.svh
// Purpose: timing constants of the unit issue hazard checker
// Assumes: cycle 1 is the leader's first execute phase
// Notes: counts are in cycles of the core clock
`ifndef UIHC_REGS_SVH
`define UIHC_REGS_SVH
`define UIHC_AGE_W 4
`define UIHC_AGE_MAX 4'hB
`define UIHC_AGE_IDLE 4'h0
// leader ages at which followers collide, age 1 is the issue cycle
`define UIHC_AGE_ISSUE 4'h2
`define UIHC_SHIFT_CLASH 4'h2
`define UIHC_FOUR_MUL16_WR 4'h3
`define UIHC_MUL_RD_FIRST 4'h2
`define UIHC_MUL_RD_LAST 4'h4
`define UIHC_I32_RES_FIRST 4'h5
`define UIHC_I32_RES_LAST 4'h7
`define UIHC_I32_MUL16_WR 4'h8
`define UIHC_WIDE_MUL16_WR_A 4'h8
`define UIHC_WIDE_MUL16_WR_B 4'h9
`define UIHC_WIDE_FOUR_RES 4'h5
`define UIHC_WIDE_FOUR_WR_A 4'h6
`define UIHC_WIDE_FOUR_WR_B 4'h7
`define UIHC_NUM_UNITS 2
`endif

// >>> include/uihc_pkg.sv
// Purpose: types of the unit issue hazard checker
// Assumes: shift unit and multiply unit of one side
// Notes: conflict codes go straight to the dispatch stage
package uihc_pkg;
    // instruction classes a leader or follower may belong to
    typedef enum logic [3:0] {
        UIHC_CLS_NONE,
        UIHC_CLS_SINGLE,
        UIHC_CLS_DP_COMPARE,
        UIHC_CLS_DP_TWO_CYCLE,
        UIHC_CLS_BRANCH_REG,
        UIHC_CLS_BRANCH_IMM,
        UIHC_CLS_MUL16,
        UIHC_CLS_FOUR_CYCLE,
        UIHC_CLS_INT_MULTIPLY_32,
        UIHC_CLS_INT_MULTIPLY_WIDE_RESULT,
        UIHC_CLS_DP_MULTIPLY,
        UIHC_CLS_LOAD,
        UIHC_CLS_STORE,
        UIHC_CLS_INT_TO_DP_CONVERT,
        UIHC_CLS_DP_ADD_SUBTRACT
    } uihc_class_t;

    typedef enum logic [2:0] {
        UIHC_CF_NONE,
        UIHC_CF_READ_DECODE_CONFLICT,
        UIHC_CF_WRITE_PORT_CONFLICT,
        UIHC_CF_READ_WRITE_CONFLICT,
        UIHC_CF_RESOURCE_CONFLICT
    } uihc_conflict_t;

    typedef enum logic [0:0] {
        UIHC_UNIT_SHIFT,
        UIHC_UNIT_MULTIPLY
    } uihc_unit_t;

    // follower offered by dispatch for the coming first_execute_phase
    typedef struct packed {
        logic valid;
        uihc_class_t cls;
        uihc_unit_t unit;
        logic cross_path;
    } uihc_req_t;

    // instruction that dispatch actually issued this cycle
    typedef struct packed {
        logic valid;
        uihc_class_t cls;
        uihc_unit_t unit;
        logic cross_path;
    } uihc_issue_t;

    typedef struct packed {
        logic blocked;
        uihc_conflict_t conflict;
    } uihc_verdict_t;
endpackage

// >>> hw/uihc_leader_track.sv
// Purpose: remembers the last leader on one unit and its age
// Assumes: issue comes from logic on the same clock
// Notes: age 1 is the leader's first execute cycle, 0 means idle
`timescale 1ns/100ps
`default_nettype none
`include "uihc_regs.svh"
module uihc_leader_track (
    input wire logic mclk_in, // core clock
    input wire logic reset_n_in, // sync reset, active low
    input wire logic issue_in, // leader enters first execute
    input wire uihc_pkg::uihc_class_t cls_in, // class of issued leader
    input wire logic cross_in, // issued leader uses cross path
    output uihc_pkg::uihc_class_t cls_out, // tracked class
    output logic cross_out, // tracked leader used cross path
    output logic [`UIHC_AGE_W-1:0] age_out // cycle of the leader
);
    import uihc_pkg::*;
    uihc_class_t cls_ff;
    logic cross_ff;
    logic [`UIHC_AGE_W-1:0] age_ff;

    // ========================================================
    // leader age
    // a false condition still holds the unit, so age runs on
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            cls_ff <= UIHC_CLS_NONE;
            cross_ff <= 1'b0;
            age_ff <= `UIHC_AGE_IDLE;
        end else if (issue_in) begin
            cls_ff <= cls_in;
            cross_ff <= cross_in;
            age_ff <= `UIHC_AGE_ISSUE;
        end else if (age_ff != `UIHC_AGE_IDLE) begin
            if (age_ff == `UIHC_AGE_MAX) begin
                age_ff <= `UIHC_AGE_IDLE;
                cls_ff <= UIHC_CLS_NONE;
            end else begin
                age_ff <= age_ff + 4'h1;
            end
        end
    end

    assign cls_out = cls_ff;
    assign cross_out = cross_ff;
    assign age_out = age_ff;
endmodule
`default_nettype wire

// >>> hw/uihc_verdict_reg.sv
// Purpose: registers the verdict shown to dispatch
// Assumes: verdict is computed on the same clock
// Notes: one cycle of latency keeps the status path short
`timescale 1ns/100ps
`default_nettype none
module uihc_verdict_reg (
    input wire logic mclk_in, // core clock
    input wire logic reset_n_in, // sync reset, active low
    input wire uihc_pkg::uihc_verdict_t nxt_in, // verdict this cycle
    output uihc_pkg::uihc_verdict_t q_out // registered verdict
);
    import uihc_pkg::*;
    uihc_verdict_t q_ff;

    // ========================================================
    // status register
    always_ff @(posedge mclk_in) begin
        if (!reset_n_in) begin
            q_ff <= '{blocked: 1'b0, conflict: UIHC_CF_NONE};
        end else begin
            q_ff <= nxt_in;
        end
    end

    assign q_out = q_ff;
endmodule
`default_nettype wire

// >>> hw/uihc_top.sv
// Purpose: issue hazard checker for the shift and multiply units
// Assumes: dispatch issues only followers that were not blocked
// Notes: age counts the leader's execute cycles from 1
//
// What this block does
// - shift single-cycle reads and writes in cycle 1; anyone may go next
// - dp compare: block same-unit single or two-cycle dp in cycle 2, rw
// - dp compare: block compare, register branch and cross followers in cycle 2
// - shift two-cycle dp: block same-unit single or two-cycle dp in cycle 2, write
// - branch reads only in cycle 1; only register branch reads registers
// - 16x16 multiply: every follower may go from cycle 2
// - four-cycle multiply: block same-unit 16x16 multiply in cycle 3
// - 32-bit multiply: block same-unit and cross followers in cycles 2 to 4, read
// - 32-bit multiply: dp multiply resource 5..7, 16x16 write in cycle 8
// - wide multiply: block same-unit and cross followers in cycles 2 to 4, read
// - wide multiply: 16x16 write 8,9; four-cycle resource 5, write 6,7
// - multi-cycle leaders keep the unit locked even if condition false
`timescale 1ns/100ps
`default_nettype none
`include "uihc_regs.svh"
module uihc_top (
    input wire logic mclk_in, // 200 MHz core clock
    input wire logic reset_n_in, // sync reset, active low
    input wire uihc_pkg::uihc_req_t req_in, // follower offered
    input wire uihc_pkg::uihc_issue_t issue_in, // instruction issued
    output logic blocked_out, // follower may not enter first execute
    output uihc_pkg::uihc_conflict_t conflict_out, // category, comb
    output uihc_pkg::uihc_verdict_t status_out // registered verdict
);
    import uihc_pkg::*;

    uihc_class_t lead_cls [`UIHC_NUM_UNITS];
    logic lead_cross [`UIHC_NUM_UNITS];
    logic [`UIHC_AGE_W-1:0] lead_age [`UIHC_NUM_UNITS];
    uihc_conflict_t unit_cf [`UIHC_NUM_UNITS];
    uihc_verdict_t nxt_verdict;

    // ========================================================
    // leader trackers, one per unit
    // a leader of a false condition is tracked just the same
    genvar gi;
    generate
        for (gi = 0; gi < `UIHC_NUM_UNITS; gi = gi + 1) begin : g_unit
            logic hit;
            assign hit = issue_in.valid &&
                (issue_in.unit == uihc_unit_t'(gi));
            uihc_leader_track u_track (
                .mclk_in(mclk_in),
                .reset_n_in(reset_n_in),
                .issue_in(hit),
                .cls_in(issue_in.cls),
                .cross_in(issue_in.cross_path),
                .cls_out(lead_cls[gi]),
                .cross_out(lead_cross[gi]),
                .age_out(lead_age[gi])
            );
        end
    endgenerate

    // ========================================================
    // follower class helpers
    function automatic logic is_reg_reader(input uihc_class_t c);
        // immediate branch reads no register, so it never collides on the cross path
        is_reg_reader = (c != UIHC_CLS_NONE) &&
            (c != UIHC_CLS_BRANCH_IMM);
    endfunction

    // ========================================================
    // conflict for a follower against one leader
    // same = follower on leader's unit; xpath = other unit, both cross
    function automatic uihc_conflict_t judge(
        input uihc_class_t lc,
        input logic [`UIHC_AGE_W-1:0] age,
        input uihc_class_t fc,
        input logic same,
        input logic xpath
    );
        uihc_conflict_t r;
        logic any;
        r = UIHC_CF_NONE;
        any = same || (xpath && is_reg_reader(fc));
        case (lc)
            UIHC_CLS_SINGLE: begin
                r = UIHC_CF_NONE;
            end
            UIHC_CLS_BRANCH_REG, UIHC_CLS_BRANCH_IMM: begin
                r = UIHC_CF_NONE;
            end
            UIHC_CLS_DP_COMPARE: begin
                if (age == `UIHC_SHIFT_CLASH) begin
                    if (same && (fc == UIHC_CLS_SINGLE ||
                        fc == UIHC_CLS_DP_TWO_CYCLE)) begin
                        r = UIHC_CF_READ_WRITE_CONFLICT;
                    end else if (same && (fc == UIHC_CLS_DP_COMPARE ||
                        fc == UIHC_CLS_BRANCH_REG)) begin
                        r = UIHC_CF_READ_DECODE_CONFLICT;
                    end else if (xpath && is_reg_reader(fc)) begin
                        r = UIHC_CF_READ_DECODE_CONFLICT;
                    end
                end
            end
            UIHC_CLS_DP_TWO_CYCLE: begin
                if (age == `UIHC_SHIFT_CLASH && same &&
                    (fc == UIHC_CLS_SINGLE ||
                    fc == UIHC_CLS_DP_TWO_CYCLE)) begin
                    r = UIHC_CF_WRITE_PORT_CONFLICT;
                end
            end
            UIHC_CLS_MUL16: begin
                r = UIHC_CF_NONE;
            end
            UIHC_CLS_FOUR_CYCLE: begin
                if (age == `UIHC_FOUR_MUL16_WR && same &&
                    fc == UIHC_CLS_MUL16) begin
                    r = UIHC_CF_WRITE_PORT_CONFLICT;
                end
            end
            UIHC_CLS_INT_MULTIPLY_32: begin
                if (age >= `UIHC_MUL_RD_FIRST &&
                    age <= `UIHC_MUL_RD_LAST && any) begin
                    r = UIHC_CF_READ_DECODE_CONFLICT;
                end else if (same && fc == UIHC_CLS_DP_MULTIPLY &&
                    age >= `UIHC_I32_RES_FIRST &&
                    age <= `UIHC_I32_RES_LAST) begin
                    r = UIHC_CF_RESOURCE_CONFLICT;
                end else if (same && fc == UIHC_CLS_MUL16 &&
                    age == `UIHC_I32_MUL16_WR) begin
                    r = UIHC_CF_WRITE_PORT_CONFLICT;
                end
            end
            UIHC_CLS_INT_MULTIPLY_WIDE_RESULT: begin
                if (age >= `UIHC_MUL_RD_FIRST &&
                    age <= `UIHC_MUL_RD_LAST && any) begin
                    r = UIHC_CF_READ_DECODE_CONFLICT;
                end else if (same && fc == UIHC_CLS_MUL16 &&
                    (age == `UIHC_WIDE_MUL16_WR_A ||
                    age == `UIHC_WIDE_MUL16_WR_B)) begin
                    r = UIHC_CF_WRITE_PORT_CONFLICT;
                end else if (same && fc == UIHC_CLS_FOUR_CYCLE &&
                    age == `UIHC_WIDE_FOUR_RES) begin
                    r = UIHC_CF_RESOURCE_CONFLICT;
                end else if (same && fc == UIHC_CLS_FOUR_CYCLE &&
                    (age == `UIHC_WIDE_FOUR_WR_A ||
                    age == `UIHC_WIDE_FOUR_WR_B)) begin
                    r = UIHC_CF_WRITE_PORT_CONFLICT;
                end
            end
            default: begin
                r = UIHC_CF_NONE;
            end
        endcase
        judge = r;
    endfunction

    // ========================================================
    // per-unit verdicts
    generate
        for (gi = 0; gi < `UIHC_NUM_UNITS; gi = gi + 1) begin : g_judge
            logic same;
            logic xpath;
            assign same = req_in.valid &&
                (req_in.unit == uihc_unit_t'(gi));
            assign xpath = req_in.valid &&
                (req_in.unit != uihc_unit_t'(gi)) &&
                req_in.cross_path && lead_cross[gi];
            assign unit_cf[gi] = judge(lead_cls[gi], lead_age[gi],
                req_in.cls, same, xpath);
        end
    endgenerate

    // ========================================================
    // merge: shift unit first, it has the earlier deadline
    always_comb begin
        nxt_verdict.conflict = UIHC_CF_NONE;
        nxt_verdict.blocked = 1'b0;
        if (unit_cf[0] != UIHC_CF_NONE) begin
            nxt_verdict.conflict = unit_cf[0];
            nxt_verdict.blocked = 1'b1;
        end else if (unit_cf[1] != UIHC_CF_NONE) begin
            nxt_verdict.conflict = unit_cf[1];
            nxt_verdict.blocked = 1'b1;
        end
    end

    assign blocked_out = nxt_verdict.blocked;
    assign conflict_out = nxt_verdict.conflict;

    uihc_verdict_reg u_status (
        .mclk_in(mclk_in),
        .reset_n_in(reset_n_in),
        .nxt_in(nxt_verdict),
        .q_out(status_out)
    );
endmodule
`default_nettype wire

// >>> testbench/uihc_top_asserts.sv
// Purpose: port-level checks of the unit issue hazard checker
// Assumes: bound into uihc_top, one clock domain
// Notes: multiply checks use plain same-unit followers only
`timescale 1ns/100ps
`default_nettype none
module uihc_top_asserts
    import uihc_pkg::*;
(
    input wire logic mclk_in, // core clock
    input wire logic reset_n_in, // sync reset, active low
    input wire uihc_pkg::uihc_req_t req_in, // follower offered
    input wire uihc_pkg::uihc_issue_t issue_in, // instruction issued
    input wire logic blocked_out, // follower blocked
    input wire uihc_pkg::uihc_conflict_t conflict_out, // category
    input wire uihc_pkg::uihc_verdict_t status_out // registered verdict
);
    // =========================================================
    // helpers
    logic mi, mq, i32, wide, rd, wr, rs;
    logic [3:0] vd;
    assign mi = issue_in.valid && issue_in.unit == UIHC_UNIT_MULTIPLY;
    // cross followers left out: a shift leader may block them as well
    assign mq = req_in.valid && req_in.unit == UIHC_UNIT_MULTIPLY
        && !req_in.cross_path;
    assign i32 = mi && issue_in.cls == UIHC_CLS_INT_MULTIPLY_32;
    assign wide = mi && issue_in.cls == UIHC_CLS_INT_MULTIPLY_WIDE_RESULT;
    assign rd = blocked_out && conflict_out == UIHC_CF_READ_DECODE_CONFLICT;
    assign wr = blocked_out && conflict_out == UIHC_CF_WRITE_PORT_CONFLICT;
    assign rs = blocked_out && conflict_out == UIHC_CF_RESOURCE_CONFLICT;
    assign vd = {blocked_out, conflict_out};
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!reset_n_in);
    // =========================================================
    // properties
    AST_STATUS_LAGS: assert property ($past(reset_n_in) |->
        status_out == $past(vd)) else $error("status is not last verdict");
    AST_CATEGORY: assert property (blocked_out ==
        (conflict_out != UIHC_CF_NONE)) else $error("category mismatch");
    AST_MUL16_FREE: assert property (mi &&
        issue_in.cls == UIHC_CLS_MUL16 ##1 mq |-> !blocked_out)
        else $error("follower of 16x16 blocked");
    AST_FOUR_MUL16: assert property (mi &&
        issue_in.cls == UIHC_CLS_FOUR_CYCLE ##1 !mi ##1 mq
        && req_in.cls == UIHC_CLS_MUL16 |-> wr) else $error("no write block");
    AST_I32_READ: assert property (i32 ##1 mq |-> rd)
        else $error("no read block after 32-bit multiply");
    AST_I32_DPM: assert property (i32 ##1 !mi [*5] ##1 mq &&
        req_in.cls == UIHC_CLS_DP_MULTIPLY |-> rs) else $error("no resource");
    AST_I32_MUL16: assert property (i32 ##1 !mi [*6] ##1 mq &&
        req_in.cls == UIHC_CLS_MUL16 |-> wr) else $error("no cycle 8 block");
    AST_WIDE_MUL16: assert property (wide ##1 !mi [*7] ##1 mq &&
        req_in.cls == UIHC_CLS_MUL16 |-> wr) else $error("no cycle 9 block");
    AST_WIDE_FOUR: assert property (wide ##1 !mi [*3] ##1 mq &&
        req_in.cls == UIHC_CLS_FOUR_CYCLE |-> rs) else $error("no cycle 5");
endmodule
bind uihc_top uihc_top_asserts chk (.mclk_in(mclk_in),
    .reset_n_in(reset_n_in), .req_in(req_in), .issue_in(issue_in),
    .blocked_out(blocked_out), .conflict_out(conflict_out),
    .status_out(status_out));
`default_nettype wire

// >>> testbench/uihc_dispatch_model.sv
// Purpose: dispatch stage model feeding the hazard checker
// Assumes: bench names the instruction and the cycle to issue it
// Notes: a blocked offer is held back, as real dispatch must do
`timescale 1ns/100ps
`default_nettype none
module uihc_dispatch_model
    import uihc_pkg::*;
(
    input wire uihc_pkg::uihc_req_t offer_in, // instruction to offer
    input wire logic fire_in, // issue the offer this cycle
    input wire logic blocked_in, // verdict from the checker
    output uihc_pkg::uihc_req_t req_out, // follower offered
    output uihc_pkg::uihc_issue_t issue_out // instruction issued
);
    assign req_out = offer_in;
    assign issue_out = (fire_in && !blocked_in) ? uihc_issue_t'(offer_in)
        : '0;
endmodule
`default_nettype wire

// >>> testbench/uihc_top_bench.sv
// Purpose: self-checking bench of the unit issue hazard checker
// Assumes: one leader per probe, follower offered in a chosen cycle
// Notes: twelve idle cycles after each probe let both trackers idle
`timescale 1ns/100ps
`default_nettype none
module uihc_top_bench;
    import uihc_pkg::*;
    localparam uihc_class_t c_i32 = UIHC_CLS_INT_MULTIPLY_32;
    localparam uihc_class_t c_wide = UIHC_CLS_INT_MULTIPLY_WIDE_RESULT;
    localparam uihc_conflict_t k_no = UIHC_CF_NONE;
    localparam uihc_conflict_t k_rd = UIHC_CF_READ_DECODE_CONFLICT;
    localparam uihc_conflict_t k_wr = UIHC_CF_WRITE_PORT_CONFLICT;
    localparam uihc_conflict_t k_rw = UIHC_CF_READ_WRITE_CONFLICT;
    localparam uihc_conflict_t k_rs = UIHC_CF_RESOURCE_CONFLICT;
    logic mclk_in = 1'b0;
    logic reset_n_in = 1'b0;
    logic fire = 1'b0;
    logic blocked;
    uihc_req_t offer = '0;
    uihc_req_t req;
    uihc_issue_t issue;
    uihc_conflict_t conflict;
    uihc_verdict_t status;
    int n_fail = 0;
    int total_checks = 0;

    always #2.5 mclk_in = ~mclk_in;

    uihc_top uut (.mclk_in(mclk_in), .reset_n_in(reset_n_in), .req_in(req),
        .issue_in(issue), .blocked_out(blocked), .conflict_out(conflict),
        .status_out(status));
    uihc_dispatch_model dispatch (.offer_in(offer), .fire_in(fire),
        .blocked_in(blocked), .req_out(req), .issue_out(issue));

    // =========================================================
    // shared tasks
    task automatic check(input string what, input logic [3:0] seen,
            input logic [3:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // ux = {leader unit, follower unit, both use cross path}
    task automatic probe(input uihc_class_t lc, input uihc_class_t fc,
            input logic [2:0] ux, input int n, input uihc_conflict_t e);
        logic [3:0] want;
        want = {e != UIHC_CF_NONE, e};
        offer = '{1'b1, lc, uihc_unit_t'(ux[2]), ux[0]};
        fire = 1'b1;
        @(posedge mclk_in);
        #1;
        fire = 1'b0;
        offer = '{1'b1, fc, uihc_unit_t'(ux[1]), ux[0]};
        repeat (n - 2) @(posedge mclk_in);
        #1;
        check("verdict", {blocked, conflict}, want);
        @(posedge mclk_in);
        #1;
        check("status", status, want);
        offer = '0;
        repeat (12) @(posedge mclk_in);
        #1;
    endtask

    // =========================================================
    // scenarios
    task automatic t_shift();
        probe(UIHC_CLS_SINGLE, UIHC_CLS_DP_COMPARE, 3'b000, 2, k_no);
        probe(UIHC_CLS_DP_COMPARE, UIHC_CLS_SINGLE, 3'b000, 2, k_rw);
        probe(UIHC_CLS_DP_COMPARE, UIHC_CLS_DP_TWO_CYCLE, 3'b000, 2,
            k_rw);
        probe(UIHC_CLS_DP_COMPARE, UIHC_CLS_SINGLE, 3'b000, 3, k_no);
        probe(UIHC_CLS_DP_COMPARE, UIHC_CLS_BRANCH_REG, 3'b000, 2,
            k_rd);
        probe(UIHC_CLS_DP_COMPARE, UIHC_CLS_MUL16, 3'b011, 2, k_rd);
        probe(UIHC_CLS_DP_COMPARE, UIHC_CLS_MUL16, 3'b011, 3, k_no);
        probe(UIHC_CLS_DP_TWO_CYCLE, UIHC_CLS_SINGLE, 3'b000, 2, k_wr);
        probe(UIHC_CLS_DP_TWO_CYCLE, UIHC_CLS_DP_TWO_CYCLE, 3'b000, 3,
            k_no);
        probe(UIHC_CLS_BRANCH_REG, UIHC_CLS_DP_COMPARE, 3'b000, 2,
            k_no);
        probe(c_i32, UIHC_CLS_BRANCH_IMM, 3'b101, 2, k_no);
    endtask

    task automatic t_multiply();
        probe(UIHC_CLS_MUL16, c_i32, 3'b110, 2, k_no);
        probe(UIHC_CLS_FOUR_CYCLE, UIHC_CLS_MUL16, 3'b110, 3, k_wr);
        probe(c_i32, UIHC_CLS_MUL16, 3'b110, 2, k_rd);
        probe(c_i32, UIHC_CLS_SINGLE, 3'b101, 4, k_rd);
        probe(c_i32, UIHC_CLS_DP_MULTIPLY, 3'b110, 7, k_rs);
        probe(c_i32, UIHC_CLS_MUL16, 3'b110, 8, k_wr);
        probe(c_i32, UIHC_CLS_MUL16, 3'b110, 9, k_no);
        probe(c_wide, UIHC_CLS_FOUR_CYCLE, 3'b110, 4, k_rd);
        probe(c_wide, UIHC_CLS_FOUR_CYCLE, 3'b110, 5, k_rs);
        probe(c_wide, UIHC_CLS_FOUR_CYCLE, 3'b110, 7, k_wr);
        probe(c_wide, UIHC_CLS_MUL16, 3'b110, 9, k_wr);
        probe(c_wide, UIHC_CLS_MUL16, 3'b110, 10, k_no);
        probe(c_wide, UIHC_CLS_MUL16, 3'b110, 8, k_wr);
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // a hang would otherwise leave the run without a verdict
    initial begin
        #20000;
        n_fail++;
        final_report();
    end

    initial begin
        repeat (3) @(posedge mclk_in);
        #1;
        reset_n_in = 1'b1;
        t_shift();
        t_multiply();
        final_report();
    end
endmodule
`default_nettype wire
